// ===== common/reset_seq_defs.svh
// constants for the reset pin sequencer: timing counts and start vectors
// assumes the sequencer clock is the bus clock, counts are in its cycles
`ifndef RESET_SEQ_DEFS_SVH
`define RESET_SEQ_DEFS_SVH

// ----------------------------------------------------------------
// timing counts, in bus clock cycles
// ----------------------------------------------------------------
`define SEQ_CNT_W 13
`define OSC_STARTUP_CYCLES 13'h1000
`define PIN_DRIVE_CYCLES 13'h0010
`define PIN_SETTLE_CYCLES 13'h0009

// ----------------------------------------------------------------
// start vector addresses (high byte of each pair)
// ----------------------------------------------------------------
`define VEC_W 16
`define VEC_NORMAL 16'hFFFE
`define VEC_CLOCK_MONITOR 16'hFFFC
`define VEC_WATCHDOG 16'hFFFA

`endif

// ===== common/reset_seq_pkg.sv
// types shared by the reset pin sequencer files
// assumes reset_seq_defs.svh is included by the files that need numbers
package reset_seq_pkg;

   // ----------------------------------------------------------------
   // sequence states, gray coded in declaration order, ST_STARTUP through ST_WAIT_HI to ST_RUN
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_STARTUP = 3'h0,
      ST_DRIVE   = 3'h1,
      ST_SETTLE  = 3'h3,
      ST_WAIT_HI = 3'h2,
      ST_RUN     = 3'h6
   } seq_state_t;

endpackage

// ===== hdl/reset_hold_sync.sv
// core reset holder: asynchronous entry, synchronous two-stage release
// assumes async_req may come from any domain, hold from clk_sys logic
`timescale 1ns/1ps

module reset_hold_sync (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // requests
   input wire logic async_req,
   input wire logic hold,
   // result
   output logic core_reset
);

   logic stage1;

   // ----------------------------------------------------------------
   // set at once, clear only after two clean edges
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge async_req) begin
      if (async_req) begin
         stage1 <= 1'b1;
         core_reset <= 1'b1;
      end else if (rst || hold) begin
         stage1 <= 1'b1;
         core_reset <= 1'b1;
      end else begin
         stage1 <= 1'b0;
         core_reset <= stage1;
      end
   end

endmodule

// ===== hdl/reset_pin_sequencer.sv
// reset pin sequencer: drives the open-drain reset pin, times recovery,
// and picks the start vector from the pin sample and failure latches
// assumes pin and clock-fail inputs are asynchronous, watchdog on clk_sys
//
// Notes on behaviour
// - reset pin is input and open-drain output
// - enter reset asynchronously, leave it synchronously
// - power-on, watchdog, clock fail, external low start sequence
// - any cause drives pin low, clocked sequence
// - power-on or clock fail: 4096 cycle startup hold
// - recovery drives pin low sixteen cycles, releases
// - sample pin nine cycles after release
// - low sample: external, clear latches, normal vector
// - high with clock fail: clock monitor vector
// - high, watchdog only: watchdog vector
// - high, no latch: normal vector
`timescale 1ns/1ps
`include "reset_seq_defs.svh"

module reset_pin_sequencer
   import reset_seq_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // reset pin, open drain
   input wire logic reset_pin_in,
   output logic reset_pin_out,
   output logic reset_pin_oe,
   // failure detectors
   input wire logic watchdog_enable,
   input wire logic watchdog_timeout,
   input wire logic clock_monitor_enable,
   input wire logic clock_fail,
   // core side
   output logic core_reset,
   output logic [`VEC_W-1:0] start_vector
);

   seq_state_t state;
   seq_state_t next_state;
   logic [`SEQ_CNT_W-1:0] count;
   logic [`SEQ_CNT_W-1:0] next_count;
   logic pin_meta;
   logic pin_sync;
   logic fail_meta;
   logic fail_sync;
   logic watchdog_latch;
   logic clock_fail_latch;
   logic watchdog_event;
   logic clock_fail_event;
   logic external_event;
   logic decide;
   logic sample_low;
   logic async_req;
   logic [`VEC_W-1:0] next_vector;

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      pin_meta <= reset_pin_in;
      pin_sync <= pin_meta;
   end

   always_ff @(posedge clk_sys) begin
      fail_meta <= clock_fail;
      fail_sync <= fail_meta;
   end

   // ----------------------------------------------------------------
   // reset causes
   // ----------------------------------------------------------------
   assign watchdog_event = watchdog_enable && watchdog_timeout;
   assign clock_fail_event = clock_monitor_enable && fail_sync;
   assign external_event = (state == ST_RUN) && !pin_sync;
   assign decide = (state == ST_SETTLE) && (count == '0);
   assign sample_low = !pin_sync;

   // ----------------------------------------------------------------
   // next state and count
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_count = count;
      unique case (state)
         ST_STARTUP: begin
            // pin held low for the whole oscillator startup
            if (count == '0) begin
               next_state = ST_DRIVE;
               next_count = `PIN_DRIVE_CYCLES - 13'h0001;
            end else begin
               next_count = count - 13'h0001;
            end
         end
         ST_DRIVE: begin
            if (count == '0) begin
               next_state = ST_SETTLE;
               // two extra cycles cover the pin synchroniser lag
               next_count = `PIN_SETTLE_CYCLES + 13'h0001;
            end else begin
               next_count = count - 13'h0001;
            end
         end
         ST_SETTLE: begin
            if (count == '0) begin
               next_state = sample_low ? ST_WAIT_HI : ST_RUN;
            end else begin
               next_count = count - 13'h0001;
            end
         end
         ST_WAIT_HI: begin
            // external request: leave only once the pin is released
            if (pin_sync) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (clock_fail_event) begin
               next_state = ST_STARTUP;
               next_count = `OSC_STARTUP_CYCLES - 13'h0001;
            end else if (watchdog_event || external_event) begin
               next_state = ST_DRIVE;
               next_count = `PIN_DRIVE_CYCLES - 13'h0001;
            end
         end
         default: begin
            next_state = ST_STARTUP;
            next_count = `OSC_STARTUP_CYCLES - 13'h0001;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // sequence register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         // power-on takes the startup hold
         state <= ST_STARTUP;
         count <= `OSC_STARTUP_CYCLES - 13'h0001;
      end else begin
         state <= next_state;
         count <= next_count;
      end
   end

   // ----------------------------------------------------------------
   // failure latches, a new event beats the clear
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         watchdog_latch <= 1'b0;
      end else if (watchdog_event) begin
         watchdog_latch <= 1'b1;
      end else if (decide) begin
         watchdog_latch <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         clock_fail_latch <= 1'b0;
      end else if (clock_fail_event) begin
         clock_fail_latch <= 1'b1;
      end else if (decide) begin
         clock_fail_latch <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // vector choice at the sample point
   // ----------------------------------------------------------------
   always_comb begin
      next_vector = start_vector;
      if (decide) begin
         if (sample_low) begin
            next_vector = `VEC_NORMAL;
         end else if (clock_fail_latch) begin
            next_vector = `VEC_CLOCK_MONITOR;
         end else if (watchdog_latch) begin
            next_vector = `VEC_WATCHDOG;
         end else begin
            next_vector = `VEC_NORMAL;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         start_vector <= `VEC_NORMAL;
      end else begin
         start_vector <= next_vector;
      end
   end

   // ----------------------------------------------------------------
   // open-drain pin drive
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         reset_pin_oe <= 1'b1;
         reset_pin_out <= 1'b0;
      end else begin
         // only ever pulls low, never drives high
         reset_pin_oe <= (next_state == ST_STARTUP) || (next_state == ST_DRIVE);
         reset_pin_out <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // core reset: asynchronous entry, synchronous release
   // ----------------------------------------------------------------
   // pin low or failed clock must reset the core even with no clock edge
   assign async_req = !reset_pin_in || (clock_monitor_enable && clock_fail);

   reset_hold_sync u_hold (
      .clk_sys(clk_sys),
      .rst(rst),
      .async_req(async_req),
      .hold(state != ST_RUN),
      .core_reset(core_reset)
   );

endmodule

// ===== test/reset_pin_sequencer_properties.sv
// port checker for the reset pin sequencer
// assumes it is bound to reset_pin_sequencer
`timescale 1ns/1ps
module reset_pin_sequencer_properties (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // pin and causes
   input wire logic reset_pin_in,
   input wire logic reset_pin_out,
   input wire logic reset_pin_oe,
   input wire logic watchdog_enable,
   input wire logic watchdog_timeout,
   input wire logic clock_monitor_enable,
   input wire logic clock_fail,
   // core side
   input wire logic core_reset,
   input wire logic [15:0] start_vector
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic [12:0] hi_cnt;
   // cycles the pin has been driven
   always_ff @(posedge clk_sys) begin
      if (rst || !reset_pin_oe) hi_cnt <= 13'h0000;
      else hi_cnt <= hi_cnt + 13'h0001;
   end
   a_pin_open_drain: assert property (!reset_pin_out)
      else $error("pin output not low");
   a_drive_length: assert property ($fell(reset_pin_oe) |-> hi_cnt == 13'h0010
      || (hi_cnt >= 13'h100F && hi_cnt <= 13'h1011)) else $error("bad drive length");
   logic [3:0] lo_cnt;
   // cycles the pin has been left free, saturating
   always_ff @(posedge clk_sys) begin
      if (rst || reset_pin_oe) lo_cnt <= 4'h0;
      else if (lo_cnt != 4'hF) lo_cnt <= lo_cnt + 4'h1;
   end
   a_settle_gap: assert property ($rose(reset_pin_oe) |-> lo_cnt >= 4'h9)
      else $error("pin driven during settle");
   a_core_held: assert property (reset_pin_oe |-> core_reset)
      else $error("core free while pin driven");
   a_pin_entry: assert property (!reset_pin_in |-> core_reset)
      else $error("pin low without core reset");
   a_clkfail_entry: assert property (clock_monitor_enable && clock_fail |-> core_reset)
      else $error("clock fail without core reset");
   a_watchdog_start: assert property (!core_reset && watchdog_enable && watchdog_timeout
      |=> reset_pin_oe) else $error("watchdog did not drive pin");
   a_external_start: assert property ($fell(reset_pin_in) && !$past(core_reset)
      |-> ##[1:4] reset_pin_oe) else $error("external low not answered");
   a_exit_released: assert property ($fell(core_reset) |-> reset_pin_in && !reset_pin_oe)
      else $error("core left reset with pin low");
   a_vector_legal: assert property (!core_reset |-> start_vector inside
      {16'hFFFE, 16'hFFFC, 16'hFFFA}) else $error("illegal start vector");
   c_release: cover property ($fell(reset_pin_oe));
   c_clock_vec: cover property (!core_reset && start_vector == 16'hFFFC);
   c_wd_vec: cover property (!core_reset && start_vector == 16'hFFFA);
endmodule
bind reset_pin_sequencer reset_pin_sequencer_properties chk_u (.clk_sys, .rst,
   .reset_pin_in, .reset_pin_out, .reset_pin_oe, .watchdog_enable, .watchdog_timeout,
   .clock_monitor_enable, .clock_fail, .core_reset, .start_vector);

// ===== test/reset_pin_circuit.sv
// board model of the reset pin: pull-up, slow rise, external low
// assumes the sequencer clock
`timescale 1ns/1ps
module reset_pin_circuit (
   // clock
   input wire logic clk_sys,
   // device side
   input wire logic reset_pin_out,
   input wire logic reset_pin_oe,
   // bench control
   input wire logic ext_low,
   input wire logic [7:0] rise_cycles,
   // pin level
   output logic pin
);
   logic [7:0] rise_cnt;
   // capacitance keeps the pin low after release
   always_ff @(posedge clk_sys) begin
      if (reset_pin_oe || ext_low) rise_cnt <= rise_cycles;
      else if (rise_cnt != 8'h00) rise_cnt <= rise_cnt - 8'h01;
   end
   // pull-up wins when nobody pulls low
   assign pin = !((reset_pin_oe && !reset_pin_out) || ext_low || rise_cnt != 8'h00);
endmodule

// ===== test/tb_reset_pin_sequencer.sv
// testbench for the reset pin sequencer
// assumes the checker is bound and the pin model stands outside
`timescale 1ns/1ps
module tb_reset_pin_sequencer;
   logic clk_sys, rst, pin, pin_out, oe, wd_en, wd_to, cm_en, cm_fail, ext_low, core_reset;
   logic [15:0] vec;
   logic [7:0] rise;
   int n_mismatch = 0;
   int num_checks = 0;
   int c;
   reset_pin_sequencer dut_u (.clk_sys(clk_sys), .rst(rst), .reset_pin_in(pin),
      .reset_pin_out(pin_out), .reset_pin_oe(oe), .watchdog_enable(wd_en),
      .watchdog_timeout(wd_to), .clock_monitor_enable(cm_en), .clock_fail(cm_fail),
      .core_reset(core_reset), .start_vector(vec));
   reset_pin_circuit far_u (.clk_sys(clk_sys), .reset_pin_out(pin_out), .reset_pin_oe(oe),
      .ext_low(ext_low), .rise_cycles(rise), .pin(pin));
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic step(int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // counts cycles the pin stays driven
   task automatic count_oe();
      c = 0;
      while (oe === 1'b1 && c < 5000) begin
         step(1);
         c++;
      end
   endtask
   task automatic wait_run(logic [15:0] exp);
      c = 0;
      while (core_reset !== 1'b0 && c < 6000) begin
         step(1);
         c++;
      end
      check("core_reset", {15'h0000, core_reset}, 16'h0000);
      check("start_vector", vec, exp);
   endtask
   task automatic power_on();
      step(6);
      rst = 1'b0;
      count_oe();
      check("startup", {15'h0000, c >= 4096 && c <= 4114}, 16'h0001);
      check("pin_out", {15'h0000, pin_out}, 16'h0000);
      wait_run(16'hFFFE);
   endtask
   task automatic watchdog_off();
      wd_to = 1'b1;
      step(1);
      wd_to = 1'b0;
      step(4);
      check("oe", {15'h0000, oe}, 16'h0000);
   endtask
   task automatic watchdog_reset();
      rise = 8'h08;
      wd_en = 1'b1;
      wd_to = 1'b1;
      step(1);
      wd_to = 1'b0;
      count_oe();
      check("drive", c[15:0], 16'h0010);
      wait_run(16'hFFFA);
   endtask
   task automatic clock_fail_alone();
      cm_fail = 1'b1;
      step(3);
      cm_fail = 1'b0;
      check("oe", {15'h0000, oe}, 16'h0001);
      count_oe();
      check("startup", c[15:0], 16'h1010);
      wait_run(16'hFFFC);
   endtask
   task automatic external_only();
      rise = 8'h00;
      ext_low = 1'b1;
      step(4);
      check("oe", {15'h0000, oe}, 16'h0001);
      ext_low = 1'b0;
      wait_run(16'hFFFE);
   endtask
   task automatic clock_fail_reset();
      cm_en = 1'b1;
      cm_fail = 1'b1;
      wd_to = 1'b1;
      step(1);
      wd_to = 1'b0;
      step(3);
      cm_fail = 1'b0;
      wait_run(16'hFFFC);
   endtask
   task automatic external_slow();
      rise = 8'h14;
      ext_low = 1'b1;
      wd_to = 1'b1;
      step(1);
      wd_to = 1'b0;
      step(3);
      ext_low = 1'b0;
      wait_run(16'hFFFE);
   endtask
   initial begin
      rst = 1'b1;
      {wd_en, wd_to, cm_en, cm_fail, ext_low} = 5'h00;
      rise = 8'h00;
      power_on();
      watchdog_off();
      watchdog_reset();
      clock_fail_reset();
      clock_fail_alone();
      external_slow();
      external_only();
      print_verdict();
   end
   initial begin
      repeat (40000) @(posedge clk_sys);
      n_mismatch++;
      print_verdict();
   end
endmodule
